// ===== rtl/irq_mask_pkg.sv
package irq_mask_pkg;

   // source layout: vector index 0 is the highest priority
   localparam int NUM_SRC      = 20;
   localparam int SRC_W        = 5;
   localparam int NUM_WAKE     = 8;
   localparam int NUM_EXT      = 4;
   localparam int NUM_INT      = 7;
   localparam int NUM_PRIO_REG = 5;

   // source index bases
   localparam logic [SRC_W-1:0] SRC_EXT_BASE  = 5'h00;
   localparam logic [SRC_W-1:0] SRC_AEC       = 5'h04;
   localparam logic [SRC_W-1:0] SRC_WAKE_BASE = 5'h05;
   localparam logic [SRC_W-1:0] SRC_INT_BASE  = 5'h0d;

   // avalon word offsets (byte address = 4 * word)
   localparam logic [3:0] OFF_LVL_A   = 4'h0;
   localparam logic [3:0] OFF_LVL_E   = 4'h4;
   localparam logic [3:0] OFF_HOLD    = 4'h5;
   localparam logic [3:0] OFF_FLAGS   = 4'h6;
   localparam logic [3:0] OFF_STATUS  = 4'h7;
   localparam logic [3:0] OFF_MASK    = 4'h8;
   localparam logic [3:0] OFF_CURRENT = 4'h9;
   localparam logic [3:0] OFF_LAST    = 4'h9;

   // field positions
   localparam int HOLD_LOW_POS  = 0;
   localparam int HOLD_HIGH_POS = 1;
   localparam int BLOCK_POS     = 7;

   // reset values
   localparam logic [7:0] LVL_RST   = 8'h00;
   localparam logic [1:0] HOLD_RST  = 2'h0;
   localparam logic       BLOCK_RST = 1'b1;

   // determination states: internal one, external pins two
   localparam int DET_INT_CYC = 1;
   localparam int DET_EXT_CYC = 2;

   localparam logic [1:0] LVL_TOP = 2'h2;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_DET,
      ST_SEND
   } fwd_state_e;

   typedef struct packed {
      logic             valid;
      logic             ext;
      logic [SRC_W-1:0] vec;
      logic [1:0]       level;
   } irq_req_s;

   typedef struct packed {
      logic       block;
      logic       hold_high;
      logic       hold_low;
   } hold_ctl_s;

endpackage : irq_mask_pkg

// ===== rtl/irq_src_sync.sv
`timescale 1ns/100ps
`default_nettype none
// two-flop synchroniser for the external request pins, one flop pair per pin
module irq_src_sync
   import irq_mask_pkg::*;
#(
   parameter int W = 1
) (
   // clock and reset
   input  wire logic         core_clk,
   input  wire logic         nrst,
   // pins and synchronised levels
   input  wire logic [W-1:0] pin_in,
   output logic      [W-1:0] pin_sync
);

   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;

   genvar g;
   generate
      for (g = 0; g < W; g++) begin : g_bit
         // first flop feeds only the second
         always_ff @(posedge core_clk) begin
            if (!nrst) begin
               meta_ff[g] <= 1'b0;
               sync_ff[g] <= 1'b0;
            end else begin
               meta_ff[g] <= pin_in[g];
               sync_ff[g] <= meta_ff[g];
            end
         end
      end
   endgenerate

   assign pin_sync = sync_ff;

endmodule // irq_src_sync
`default_nettype wire

// ===== rtl/irq_mask_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
// How it works
// - every maskable source gets a mask level 2, 1 or 0 from its own level register field.
// - each level register holds four 2-bit fields at bits 7:6, 5:4, 3:2 and 1:0, values 0 to 3.
// - the non-maskable and address break requests bypass every level setting.
// - wake pins, external pins, the event counter pin and internal requests all have a level field.
// - a lower vector number wins over a higher one, but does not pre-empt a request already in determination or being sent.
// - priority among sources of one peripheral is fixed by its vector order.
// - while the block bit in the cpu flags is 1 no maskable request is forwarded.
// - block 0 and hold high bit 1 lets only level 2 requests through.
// - block 0, hold high 0 and hold low 1 holds only level 0 requests pending.
// - block and both hold bits at 0 accept every maskable request.
// - among requests not held the lowest vector wins, levels play no part.
// - a request reaches the cpu only after its level has been determined.
// - level determination takes one cycle for internal and two for external pin sources.
module irq_mask_ctrl
   import irq_mask_pkg::*;
(
   // clock and reset
   input  wire logic                core_clk,
   input  wire logic                nrst,
   // avalon-mm slave
   input  wire logic [3:0]          avs_address,
   input  wire logic                avs_read,
   input  wire logic                avs_write,
   input  wire logic [31:0]         avs_writedata,
   output logic      [31:0]         avs_readdata,
   output logic                     avs_waitrequest,
   // request sources
   input  wire logic [NUM_EXT-1:0]  ext_pin_req,
   input  wire logic                event_counter_pin_req,
   input  wire logic [NUM_WAKE-1:0] wake_pin_req,
   input  wire logic [NUM_INT-1:0]  periph_req,
   input  wire logic                nmi_req,
   input  wire logic                brk_req,
   // cpu side
   output logic                     cpu_irq,
   output logic [SRC_W-1:0]         cpu_vec,
   input  wire logic                cpu_ack,
   output logic                     cpu_nmi,
   output logic                     cpu_brk,
   // interrupt output of this block
   output logic                     irq_out
);

   logic [7:0]          lvl_ff [NUM_PRIO_REG];
   hold_ctl_s           hold_ff;
   logic [NUM_SRC-1:0]  raw_req;
   logic [NUM_SRC-1:0]  pin_sync;
   logic [NUM_SRC-1:0]  src_ext;
   logic [1:0]          src_lvl [NUM_SRC];
   logic [NUM_SRC-1:0]  pass;
   irq_req_s            nxt_win;
   irq_req_s            win_ff;
   fwd_state_e          st_ff;
   logic                det_cnt_ff;
   logic [2:0]          sts_ff;
   logic [2:0]          msk_ff;
   logic [2:0]          evt;
   logic [31:0]         rdata_ff;
   logic                rd_pend_ff;
   logic                wr;
   logic                sel_lvl;

   // external pins cross in through two flops; internal requests are on core_clk
   irq_src_sync #(.W(NUM_EXT + 1 + NUM_WAKE)) u_sync (
      .core_clk (core_clk),
      .nrst     (nrst),
      .pin_in   ({wake_pin_req, event_counter_pin_req, ext_pin_req}),
      .pin_sync (pin_sync[NUM_EXT+NUM_WAKE:0])
   );
   assign pin_sync[NUM_SRC-1:NUM_EXT+NUM_WAKE+1] = '0;
   assign raw_req = {periph_req, pin_sync[NUM_EXT+NUM_WAKE:0]};

   // per-source level lookup: four fields per register, 3 folds onto 2
   genvar g;
   generate
      for (g = 0; g < NUM_SRC; g++) begin : g_src
         logic [1:0] fld;
         assign fld = lvl_ff[g/4][(g%4)*2 +: 2];
         assign src_lvl[g] = (fld == 2'h3) ? LVL_TOP : fld;
         assign src_ext[g] = (g < NUM_EXT + 1 + NUM_WAKE);
         // hold decision from block and hold mode bits
         assign pass[g] = raw_req[g] && !hold_ff.block &&
                          (hold_ff.hold_high ? (src_lvl[g] == LVL_TOP) :
                           hold_ff.hold_low  ? (src_lvl[g] != 2'h0) :
                           1'b1);
      end
   endgenerate

   // fixed priority: lowest index wins, levels not consulted
   always_comb begin
      nxt_win = '0;
      for (int i = NUM_SRC - 1; i >= 0; i--) begin
         if (pass[i]) begin
            nxt_win.valid = 1'b1;
            nxt_win.vec   = SRC_W'(i);
            nxt_win.ext   = src_ext[i];
            nxt_win.level = src_lvl[i];
         end
      end
   end

   // determination and forwarding sequence; the request must still pass when sent
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         st_ff      <= ST_IDLE;
         win_ff     <= '0;
         det_cnt_ff <= 1'b0;
      end else begin
         case (st_ff)
            ST_IDLE: begin
               if (nxt_win.valid) begin
                  win_ff     <= nxt_win;
                  det_cnt_ff <= nxt_win.ext;
                  st_ff      <= ST_DET;
               end
            end
            ST_DET: begin
               if (!pass[win_ff.vec]) begin
                  st_ff <= ST_IDLE;                                        // dropped or now held
               end else if (det_cnt_ff) begin
                  det_cnt_ff <= 1'b0;                                      // second external state
               end else begin
                  st_ff <= ST_SEND;
               end
            end
            ST_SEND: begin
               if (cpu_ack || !pass[win_ff.vec]) begin
                  st_ff <= ST_IDLE;
               end
            end
            default: st_ff <= ST_IDLE;
         endcase
      end
   end

   assign cpu_irq = (st_ff == ST_SEND) && pass[win_ff.vec];
   assign cpu_vec = win_ff.vec;
   // non-maskable paths ignore levels and hold bits
   assign cpu_nmi = nmi_req;
   assign cpu_brk = brk_req;

   // events: request forwarded, request acked, maskable request held pending
   assign evt[0] = cpu_irq;
   assign evt[1] = cpu_irq && cpu_ack;
   assign evt[2] = |(raw_req & ~pass);

   assign wr      = avs_write && !rd_pend_ff;
   assign sel_lvl = (avs_address <= OFF_LVL_E);

   // level registers
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         for (int i = 0; i < NUM_PRIO_REG; i++) lvl_ff[i] <= LVL_RST;
      end else if (wr && sel_lvl) begin
         lvl_ff[avs_address[2:0]] <= avs_writedata[7:0];
      end
   end

   // hold mode and block bit; block resets set so nothing leaks out before setup
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         hold_ff <= {BLOCK_RST, HOLD_RST};
      end else if (wr && avs_address == OFF_HOLD) begin
         hold_ff.hold_high <= avs_writedata[HOLD_HIGH_POS];
         hold_ff.hold_low  <= avs_writedata[HOLD_LOW_POS];
      end else if (wr && avs_address == OFF_FLAGS) begin
         hold_ff.block <= avs_writedata[BLOCK_POS];
      end
   end

   // sticky status: set beats a write-one clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         sts_ff <= '0;
         msk_ff <= '0;
      end else begin
         sts_ff <= (sts_ff & ~((wr && avs_address == OFF_STATUS) ? avs_writedata[2:0] : 3'h0)) | evt;
         if (wr && avs_address == OFF_MASK) msk_ff <= avs_writedata[2:0];
      end
   end
   assign irq_out = |(sts_ff & msk_ff);

   // reads take one wait cycle so data come from a flop
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         rd_pend_ff <= 1'b0;
         rdata_ff   <= '0;
      end else begin
         rd_pend_ff <= avs_read && !rd_pend_ff;
         if (avs_read && !rd_pend_ff) begin
            if (sel_lvl)                          rdata_ff <= {24'h0, lvl_ff[avs_address[2:0]]};
            else if (avs_address == OFF_HOLD)     rdata_ff <= {30'h0, hold_ff.hold_high, hold_ff.hold_low};
            else if (avs_address == OFF_FLAGS)    rdata_ff <= {24'h0, hold_ff.block, 7'h0};
            else if (avs_address == OFF_STATUS)   rdata_ff <= {29'h0, sts_ff};
            else if (avs_address == OFF_MASK)     rdata_ff <= {29'h0, msk_ff};
            else if (avs_address == OFF_CURRENT)  rdata_ff <= {22'h0, cpu_irq, win_ff.level, win_ff.ext, 1'b0, win_ff.vec};
            else                                  rdata_ff <= '0;
         end
      end
   end

   assign avs_readdata    = rdata_ff;
   assign avs_waitrequest = avs_read && !rd_pend_ff;

endmodule // irq_mask_ctrl
`default_nettype wire

// ===== tb/irq_mask_asserts.sv
`timescale 1ns/100ps
`default_nettype none
// port checker; control registers are shadowed from bus writes
module irq_mask_asserts
   import irq_mask_pkg::*;
(
   // clock and reset
   input wire logic               core_clk,
   input wire logic               nrst,
   // register bus
   input wire logic [3:0]         avs_address,
   input wire logic               avs_read,
   input wire logic               avs_write,
   input wire logic [31:0]        avs_writedata,
   input wire logic               avs_waitrequest,
   // sources and cpu side
   input wire logic [NUM_INT-1:0] periph_req,
   input wire logic               nmi_req,
   input wire logic               brk_req,
   input wire logic               cpu_irq,
   input wire logic [SRC_W-1:0]   cpu_vec,
   input wire logic               cpu_nmi,
   input wire logic               cpu_brk,
   input wire logic               irq_out
);
   logic [7:0]         lvl_ff [NUM_PRIO_REG];
   logic [1:0]         hold_ff;
   logic               blk_ff;
   logic [2:0]         msk_ff;
   logic [NUM_INT-1:0] pr1_ff;
   logic [NUM_INT-1:0] pr2_ff;
   logic [1:0]         fld;
   logic [1:0]         eff_lvl;
   // shadow copy of the control registers, same reset values as the block
   always_ff @(posedge core_clk) begin
      if (!nrst) begin
         for (int i = 0; i < NUM_PRIO_REG; i++) lvl_ff[i] <= LVL_RST;
         hold_ff <= HOLD_RST;
         blk_ff <= BLOCK_RST;
         msk_ff <= 3'h0;
      end else if (avs_write) begin
         if (avs_address < 4'h5) lvl_ff[avs_address] <= avs_writedata[7:0];
         if (avs_address == OFF_HOLD) hold_ff <= avs_writedata[1:0];
         if (avs_address == OFF_FLAGS) blk_ff <= avs_writedata[BLOCK_POS];
         if (avs_address == OFF_MASK) msk_ff <= avs_writedata[2:0];
      end
   end
   // request history for the determination delay
   always_ff @(posedge core_clk) begin
      pr1_ff <= periph_req;
      pr2_ff <= pr1_ff;
   end
   // level of the forwarded vector, 3 counted as the top level
   always_comb begin
      fld = lvl_ff[cpu_vec[4:2]][{cpu_vec[1:0], 1'b0} +: 2];
      eff_lvl = (fld == 2'h3) ? LVL_TOP : fld;
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!nrst);
   sequence rd_start; avs_read && !$past(avs_read); endsequence
   sequence one_wait; avs_waitrequest ##1 !avs_waitrequest; endsequence
   nmi_pass_a: assert property (cpu_nmi == nmi_req)
      else $error("nmi not passed through");
   brk_pass_a: assert property (cpu_brk == brk_req)
      else $error("break not passed through");
   block_hold_a: assert property (blk_ff |-> !cpu_irq)
      else $error("request forwarded while blocked");
   high_hold_a: assert property (cpu_irq && !blk_ff && hold_ff[1] |-> eff_lvl == LVL_TOP)
      else $error("low level passed in high hold");
   low_hold_a: assert property (cpu_irq && !blk_ff && hold_ff == 2'h1 |-> eff_lvl != 2'h0)
      else $error("level 0 passed in low hold");
   vec_stable_a: assert property (cpu_irq && $past(cpu_irq) |-> $stable(cpu_vec))
      else $error("vector changed during request");
   det_delay_a: assert property ($rose(cpu_irq) && cpu_vec >= SRC_INT_BASE |-> pr2_ff[cpu_vec - SRC_INT_BASE])
      else $error("internal request forwarded too early");
   mask_quiet_a: assert property (msk_ff == 3'h0 |-> !irq_out)
      else $error("interrupt with all masked");
   read_wait_a: assert property (rd_start |-> one_wait)
      else $error("read wait cycle wrong");
endmodule // irq_mask_asserts
bind irq_mask_ctrl irq_mask_asserts u_chk (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
   .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
   .periph_req(periph_req), .nmi_req(nmi_req), .brk_req(brk_req), .cpu_irq(cpu_irq), .cpu_vec(cpu_vec),
   .cpu_nmi(cpu_nmi), .cpu_brk(cpu_brk), .irq_out(irq_out));
`default_nettype wire

// ===== tb/cpu_core_model.sv
`timescale 1ns/100ps
`default_nettype none
// cpu core: acknowledges a forwarded request after ACK_DLY cycles unless held
module cpu_core_model #(
   parameter int ACK_DLY = 1
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic nrst,
   // link to the controller
   input wire logic cpu_irq,
   input wire logic hold_ack,
   output logic     cpu_ack
);
   int cnt_ff;
   // one-cycle pulse; a held core lets the request stand
   always_ff @(posedge core_clk) begin
      if (!nrst || cpu_ack || !cpu_irq || hold_ack) begin
         cpu_ack <= 1'b0;
         cnt_ff <= 0;
      end else if (cnt_ff == ACK_DLY - 1) begin
         cpu_ack <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + 1;
      end
   end
endmodule // cpu_core_model
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import irq_mask_pkg::*;
   logic               core_clk = 1'b0;
   logic               nrst = 1'b0;
   logic [3:0]         avs_address = 4'h0;
   logic               avs_read = 1'b0;
   logic               avs_write = 1'b0;
   logic [31:0]        avs_writedata = 32'h0;
   logic [31:0]        avs_readdata;
   logic               avs_waitrequest;
   logic [NUM_SRC-1:0] src = '0; // one bit per vector
   logic               nmi_req = 1'b0;
   logic               brk_req = 1'b0;
   logic               hold_ack = 1'b1;
   logic               cpu_irq, cpu_ack, cpu_nmi, cpu_brk, irq_out;
   logic [SRC_W-1:0]   cpu_vec;
   int                 miscompares = 0, checked = 0, cyc = 0, ni, ne;
   initial forever #4 core_clk = ~core_clk;
   irq_mask_ctrl i_irq_mask_ctrl (.core_clk(core_clk), .nrst(nrst), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .ext_pin_req(src[3:0]), .event_counter_pin_req(src[4]),
      .wake_pin_req(src[12:5]), .periph_req(src[19:13]), .nmi_req(nmi_req), .brk_req(brk_req),
      .cpu_irq(cpu_irq), .cpu_vec(cpu_vec), .cpu_ack(cpu_ack), .cpu_nmi(cpu_nmi), .cpu_brk(cpu_brk),
      .irq_out(irq_out));
   cpu_core_model i_cpu_core_model (.core_clk(core_clk), .nrst(nrst), .cpu_irq(cpu_irq),
      .hold_ack(hold_ack), .cpu_ack(cpu_ack));
   // cycle ceiling cuts a hang short
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 20000) begin
         miscompares++;
         final_report;
      end
   end
   task automatic final_report;
      $display("compares %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask
   // bus cycles hold the request until waitrequest is sampled low
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge core_clk); while (avs_waitrequest);
      avs_write <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp, input string nm);
      @(posedge core_clk);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge core_clk); while (avs_waitrequest);
      avs_read <= 1'b0;
      chk(nm, exp, avs_readdata);
   endtask
   task automatic wait_irq(input int lim, output int n);
      n = 0;
      do begin @(posedge core_clk); n++; end while (!cpu_irq && n < lim);
   endtask
   task automatic wait_low;
      do @(posedge core_clk); while (cpu_irq);
   endtask
   task automatic t_reset;
      for (int i = 0; i < NUM_PRIO_REG; i++) rd(i[3:0], 32'h0, "level reg");
      rd(OFF_FLAGS, 32'h80, "flags");
      rd(4'hf, 32'h0, "unmapped");
      @(posedge core_clk);
      src[13] <= 1'b1;
      nmi_req <= 1'b1;
      brk_req <= 1'b1;
      wait_irq(10, ni);
      chk("held", 32'h0, 32'(cpu_irq));
      chk("nmi", 32'h1, 32'(cpu_nmi));
      chk("brk", 32'h1, 32'(cpu_brk));
      rd(OFF_STATUS, 32'h4, "status held");
      src[13] <= 1'b0;
      nmi_req <= 1'b0;
      brk_req <= 1'b0;
   endtask
   // every hold mode against every level, each level on its own field
   task automatic t_levels;
      logic [4:0] v;
      wr(OFF_FLAGS, 32'h0);
      for (int h = 0; h < 4; h++) begin
         for (int l = 0; l < 4; l++) begin
            v = SRC_INT_BASE + 5'(l);
            wr({1'b0, v[4:2]}, 32'(l) << (v[1:0] * 2));
            wr(OFF_HOLD, 32'(h));
            @(posedge core_clk);
            src[v] <= 1'b1;
            wait_irq(8, ni);
            chk("forwarded", 32'(h[1] ? l >= 2 : (h[0] ? l != 0 : 1)), 32'(cpu_irq));
            src[v] <= 1'b0;
            wait_low;
         end
      end
   endtask
   // all pending while blocked, released at once; levels must not matter
   task automatic t_prio;
      logic [4:0] exp_v [5] = '{5'h01, 5'h04, 5'h08, 5'h0d, 5'h13};
      rd(OFF_HOLD, 32'h3, "hold mode");
      wr(OFF_FLAGS, 32'h80);
      wr(OFF_HOLD, 32'h0);
      wr(4'h4, 32'hc0);
      @(posedge core_clk);
      foreach (exp_v[i]) src[exp_v[i]] <= 1'b1;
      repeat (4) @(posedge core_clk);
      wr(OFF_FLAGS, 32'h0);
      foreach (exp_v[i]) begin
         wait_irq(20, ni);
         chk("winner", 32'(exp_v[i]), 32'(cpu_vec));
         src[cpu_vec] <= 1'b0;
         wait_low;
      end
   endtask
   task automatic t_ack;
      wr(OFF_MASK, 32'h0);
      wr(OFF_STATUS, 32'h7);
      hold_ack <= 1'b0;
      @(posedge core_clk);
      src[13] <= 1'b1;
      wait_irq(20, ni);
      do @(posedge core_clk); while (!cpu_ack);
      src[13] <= 1'b0;
      rd(OFF_STATUS, 32'h3, "status");
      chk("irq masked", 32'h0, 32'(irq_out));
      wr(OFF_MASK, 32'h1);
      @(posedge core_clk);
      chk("irq raised", 32'h1, 32'(irq_out));
      wr(OFF_STATUS, 32'h1);
      rd(OFF_STATUS, 32'h2, "status cleared");
      chk("irq cleared", 32'h0, 32'(irq_out));
      @(posedge core_clk);
      src[0] <= 1'b1;
      wait_irq(20, ne);
      chk("ext extra delay", 32'h3, 32'(ne - ni));
      chk("int delay", 32'h1, 32'(ni > 2));
   endtask
   initial begin
      repeat (10) @(posedge core_clk);
      nrst <= 1'b1;
      t_reset;
      t_levels;
      t_prio;
      t_ack;
      final_report;
   end
endmodule // testbench
`default_nettype wire
